/* File: inc/mstop_params.svh */
// Constants of the motor stop-mode controller
`ifndef MSTOP_PARAMS_SVH
`define MSTOP_PARAMS_SVH
// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define MSTOP_CLK_HZ 50000000
`define MSTOP_DC_T1_MS 500
`define MSTOP_DC_T2_MS 500
// ----------------------------------------------------------------------------
// Stop source assignment codes (6 bits)
// ----------------------------------------------------------------------------
`define MSTOP_SRC_NONE 6'h00
`define MSTOP_SRC_BASE_LSB 1
`define MSTOP_SRC_EXT_LSB 7
`define MSTOP_SRC_LOCAL_LSB 16
`define MSTOP_SRC_SERIAL_LSB 32
`define MSTOP_SRC_FIELDBUS_LSB 48
`define MSTOP_SRC_PHYS_LAST 6'h0C
// ----------------------------------------------------------------------------
// Reset values and ranges (speed in 0.1 Hz, ramp time in 0.1 s)
// ----------------------------------------------------------------------------
`define MSTOP_THD_MIN 13'h0002
`define MSTOP_THD_MAX 13'h1388
`define MSTOP_DIV_MAX 4'hA
`define MSTOP_DIV_RESET 4'h4
`define MSTOP_RAMP_MIN 16'h0001
`endif

/* File: inc/mstop_pkg.sv */
// Types of the motor stop-mode controller
package mstop_pkg;
   // Normal stop mode, ramp is the reset choice
   typedef enum logic [1:0] {
      MSTOP_MODE_RAMP = 2'b00,
      MSTOP_MODE_FAST = 2'b01,
      MSTOP_MODE_FREEWHEEL = 2'b10,
      MSTOP_MODE_DCINJ = 2'b11
   } mstop_mode_type;
   // Controller state
   typedef enum logic [2:0] {
      MSTOP_ST_IDLE = 3'b000,
      MSTOP_ST_RUN = 3'b001,
      MSTOP_ST_RAMP = 3'b010,
      MSTOP_ST_FAST = 3'b011,
      MSTOP_ST_FREEWHEEL = 3'b100,
      MSTOP_ST_DCINJ = 3'b101
   } mstop_state_type;
endpackage

/* File: hw/mstop_src_select.sv */
// Stop source selector: picks one assignable source and keeps its last two samples
`timescale 1ns/1ps
`default_nettype none
`include "mstop_params.svh"
module mstop_src_select (
   input wire logic clk, // Control clock
   input wire logic srst, // Synchronous reset
   input wire logic [5:0] src_code, // Source assignment code
   input wire logic [5:0] base_inputs, // Base digital inputs
   input wire logic [5:0] extension_inputs, // Extension digital inputs
   input wire logic [15:0] virtual_input_zero, // Local command word
   input wire logic [15:0] serial_command_word, // Serial command word
   input wire logic [15:0] fieldbus_command_word, // Fieldbus command word
   output logic cur_q, // Current sample
   output logic prev_q, // Previous sample
   output logic assigned_q, // Source assigned
   output logic physical_q // Source is a physical input
);
   logic [63:0] src_vec;
   logic cur_d;
   logic prev_d;
   logic assigned_d;
   logic physical_d;

   // ----------------------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------------------
   // Unused codes read a constant zero, so they never toggle
   always_comb begin
      src_vec = {fieldbus_command_word, serial_command_word, virtual_input_zero, 3'h0,
                 extension_inputs, base_inputs, 1'b0};
      assigned_d = (src_code != `MSTOP_SRC_NONE);
      physical_d = assigned_d && (src_code <= `MSTOP_SRC_PHYS_LAST);
      // Holding the old sample when unassigned keeps a change of code from faking an edge
      cur_d = assigned_d ? src_vec[src_code] : cur_q;
      prev_d = cur_q;
   end

   // Sample every clock, previous sample for edge detection
   always_ff @(posedge clk) begin
      if (srst) begin
         cur_q <= 1'b1;
         prev_q <= 1'b1;
         assigned_q <= 1'b0;
         physical_q <= 1'b0;
      end else begin
         cur_q <= cur_d;
         prev_q <= prev_d;
         assigned_q <= assigned_d;
         physical_q <= physical_d;
      end
   end
endmodule
`default_nettype wire

/* File: hw/mstop_ctrl.sv */
// Motor stop-mode controller: stop selection, stop inputs, restart interlock
// Summary of operation
// - Apply normal stop when run drops or stop.
// - Four stop modes; ramp stop after reset.
// - Freewheel starts on source falling to zero.
// - Freewheel/fast release restarts only two-wire level.
// - DC release restarts only two-wire level.
// - Sources: three command words, two input banks.
// - Below threshold, ramp/fast becomes freewheel with auto-DC.
// - Freewheel threshold 0.2 to 500 Hz, default 0.2.
// - Fast stop: input falls or bit rises.
// - Fast stop divides selected deceleration ramp.
// - Divider 0 to 10, default 4, 0 minimum.
// - DC injection starts on source rising; active high.
// - Sources default unassigned; unassigned never triggers.
// - DC level one for time one, then two.
`timescale 1ns/1ps
`default_nettype none
`include "mstop_params.svh"
module mstop_ctrl #(
   parameter int DC_T1_CYC = `MSTOP_DC_T1_MS * (`MSTOP_CLK_HZ / 1000), // Injection time one
   parameter int DC_T2_CYC = `MSTOP_DC_T2_MS * (`MSTOP_CLK_HZ / 1000) // Injection time two
) (
   input wire logic clk, // Control clock, 50 MHz
   input wire logic srst, // Synchronous reset, active high
   input wire logic run_cmd, // Run command level
   input wire logic stop_cmd, // Stop command level
   input wire mstop_pkg::mstop_mode_type stop_mode, // Normal stop mode
   input wire logic [5:0] freewheel_assign, // Freewheel source code
   input wire logic [5:0] fast_assign, // Fast stop source code
   input wire logic [5:0] dcinj_assign, // DC injection source code
   input wire logic [5:0] base_inputs, // Base inputs, first to last
   input wire logic [5:0] extension_inputs, // Extension inputs, first to last
   input wire logic [15:0] virtual_input_zero, // Local command word
   input wire logic [15:0] serial_command_word, // Serial command word
   input wire logic [15:0] fieldbus_command_word, // Fieldbus command word
   input wire logic two_wire_ctrl, // Two-wire control selected
   input wire logic two_wire_level, // Two-wire type level or forward priority
   input wire logic auto_dc_inj_en, // Automatic DC injection configured
   input wire logic [12:0] motor_speed, // Motor speed, 0.1 Hz
   input wire logic [12:0] freewheel_thd, // Freewheel threshold, 0.1 Hz
   input wire logic [3:0] ramp_divider, // Fast stop ramp divider
   input wire logic decel_sel_second, // Second deceleration ramp enabled
   input wire logic [15:0] decel_time1, // First deceleration time, 0.1 s
   input wire logic [15:0] decel_time2, // Second deceleration time, 0.1 s
   output mstop_pkg::mstop_state_type stop_state_q, // Controller state
   output logic motor_run_q, // Motor driven
   output logic dc_second_level_q, // DC injection at level two
   output logic restart_lock_q, // New run command needed
   output logic [15:0] fast_decel_time_q, // Fast stop deceleration time
   output logic [12:0] freewheel_thd_q // Threshold in force
);
   import mstop_pkg::*;

   // ----------------------------------------------------------------------------
   // Stop sources
   // ----------------------------------------------------------------------------
   logic [5:0] code_arr [3];
   logic [2:0] cur;
   logic [2:0] prev;
   logic [2:0] asg;
   logic [2:0] phys;
   assign code_arr[0] = freewheel_assign;
   assign code_arr[1] = fast_assign;
   assign code_arr[2] = dcinj_assign;

   // One selector per stop function: 0 freewheel, 1 fast, 2 DC injection
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_src
         mstop_src_select u_sel (
            .clk(clk),
            .srst(srst),
            .src_code(code_arr[gi]),
            .base_inputs(base_inputs),
            .extension_inputs(extension_inputs),
            .virtual_input_zero(virtual_input_zero),
            .serial_command_word(serial_command_word),
            .fieldbus_command_word(fieldbus_command_word),
            .cur_q(cur[gi]),
            .prev_q(prev[gi]),
            .assigned_q(asg[gi]),
            .physical_q(phys[gi])
         );
      end
   endgenerate

   // Edges and holding levels; unassigned sources are masked out
   logic fw_edge;
   logic fast_edge;
   logic dc_edge;
   logic fw_hold;
   logic fast_hold;
   logic dc_hold;
   logic auto_ok;
   always_comb begin
      fw_edge = asg[0] && prev[0] && !cur[0];
      fast_edge = asg[1] && (phys[1] ? (prev[1] && !cur[1]) : (!prev[1] && cur[1]));
      dc_edge = asg[2] && !prev[2] && cur[2];
      fw_hold = asg[0] && !cur[0];
      fast_hold = asg[1] && (phys[1] ? !cur[1] : cur[1]);
      dc_hold = asg[2] && cur[2];
      auto_ok = two_wire_ctrl && two_wire_level;
   end

   // ----------------------------------------------------------------------------
   // Settings in force
   // ----------------------------------------------------------------------------
   logic [15:0] fast_decel_time_d;
   logic [12:0] freewheel_thd_d;
   logic [15:0] decel_sel;
   logic [3:0] div_eff;
   always_comb begin
      decel_sel = decel_sel_second ? decel_time2 : decel_time1;
      div_eff = (ramp_divider > `MSTOP_DIV_MAX) ? `MSTOP_DIV_MAX : ramp_divider;
      // Zero divider asks for the shortest ramp; a quotient of zero is lifted to it too
      if (div_eff == 4'h0) begin
         fast_decel_time_d = `MSTOP_RAMP_MIN;
      end else begin
         fast_decel_time_d = decel_sel / {12'h000, div_eff};
         if (fast_decel_time_d == 16'h0000) begin
            fast_decel_time_d = `MSTOP_RAMP_MIN;
         end
      end
      // Out-of-range threshold is clamped rather than rejected
      if (freewheel_thd < `MSTOP_THD_MIN) begin
         freewheel_thd_d = `MSTOP_THD_MIN;
      end else if (freewheel_thd > `MSTOP_THD_MAX) begin
         freewheel_thd_d = `MSTOP_THD_MAX;
      end else begin
         freewheel_thd_d = freewheel_thd;
      end
   end

   // ----------------------------------------------------------------------------
   // Stop state machine
   // ----------------------------------------------------------------------------
   mstop_state_type state_d;
   logic motor_run_d;
   logic dc_second_level_d;
   logic restart_lock_d;
   logic input_stop_q;
   logic input_stop_d;
   logic [31:0] dc_cnt_q;
   logic [31:0] dc_cnt_d;
   logic speed_zero;
   logic below_thd;
   always_comb begin
      state_d = stop_state_q;
      input_stop_d = input_stop_q;
      restart_lock_d = restart_lock_q && run_cmd;
      dc_cnt_d = dc_cnt_q;
      speed_zero = (motor_speed == 13'h0000);
      below_thd = (motor_speed < freewheel_thd_q);
      // Input stops outrank the normal stop: freewheel, then fast, then DC
      if (fw_edge) begin
         state_d = MSTOP_ST_FREEWHEEL;
         input_stop_d = 1'b1;
      end else if (fast_edge) begin
         state_d = MSTOP_ST_FAST;
         input_stop_d = 1'b1;
      end else if (dc_edge) begin
         state_d = MSTOP_ST_DCINJ;
         input_stop_d = 1'b1;
         dc_cnt_d = 32'h0000_0000;
      end else begin
         case (stop_state_q)
            MSTOP_ST_IDLE: begin
               // A held stop input keeps the motor off
               if (run_cmd && !stop_cmd && !restart_lock_q && !fw_hold && !fast_hold && !dc_hold) begin
                  state_d = MSTOP_ST_RUN;
               end
               input_stop_d = 1'b0;
            end
            MSTOP_ST_RUN: begin
               if (!run_cmd || stop_cmd) begin
                  input_stop_d = 1'b0;
                  dc_cnt_d = 32'h0000_0000;
                  case (stop_mode)
                     MSTOP_MODE_RAMP: state_d = MSTOP_ST_RAMP;
                     MSTOP_MODE_FAST: state_d = MSTOP_ST_FAST;
                     MSTOP_MODE_FREEWHEEL: state_d = MSTOP_ST_FREEWHEEL;
                     default: state_d = MSTOP_ST_DCINJ;
                  endcase
               end
            end
            MSTOP_ST_RAMP, MSTOP_ST_FAST: begin
               if (auto_dc_inj_en && below_thd && !speed_zero) begin
                  state_d = MSTOP_ST_FREEWHEEL;
               end else if (speed_zero && !fast_hold) begin
                  state_d = MSTOP_ST_IDLE;
               end
            end
            MSTOP_ST_FREEWHEEL: begin
               // An input stop ends on release; a mode stop when the shaft stops
               if (!fw_hold && !fast_hold && (speed_zero || input_stop_q)) begin
                  state_d = MSTOP_ST_IDLE;
               end
            end
            MSTOP_ST_DCINJ: begin
               if (dc_cnt_q != 32'hFFFF_FFFF) begin
                  dc_cnt_d = dc_cnt_q + 32'h0000_0001;
               end
               if (input_stop_q ? !dc_hold : (dc_cnt_q >= 32'(DC_T1_CYC + DC_T2_CYC - 1))) begin
                  state_d = MSTOP_ST_IDLE;
               end
            end
            default: state_d = MSTOP_ST_IDLE;
         endcase
      end
      // Leaving an input stop with run held needs a fresh run unless two-wire level
      if (input_stop_q && stop_state_q != MSTOP_ST_IDLE && state_d == MSTOP_ST_IDLE && run_cmd && !auto_ok) begin
         restart_lock_d = 1'b1;
      end
      motor_run_d = (state_d == MSTOP_ST_RUN);
      dc_second_level_d = (state_d == MSTOP_ST_DCINJ) && (dc_cnt_d >= 32'(DC_T1_CYC));
   end

   // State registers
   always_ff @(posedge clk) begin
      if (srst) begin
         stop_state_q <= MSTOP_ST_IDLE;
         motor_run_q <= 1'b0;
         dc_second_level_q <= 1'b0;
         restart_lock_q <= 1'b0;
         input_stop_q <= 1'b0;
         dc_cnt_q <= 32'h0000_0000;
         fast_decel_time_q <= `MSTOP_RAMP_MIN;
         freewheel_thd_q <= `MSTOP_THD_MIN;
      end else begin
         stop_state_q <= state_d;
         motor_run_q <= motor_run_d;
         dc_second_level_q <= dc_second_level_d;
         restart_lock_q <= restart_lock_d;
         input_stop_q <= input_stop_d;
         dc_cnt_q <= dc_cnt_d;
         fast_decel_time_q <= fast_decel_time_d;
         freewheel_thd_q <= freewheel_thd_d;
      end
   end

   // ----------------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------------
   logic no_edge;
   assign no_edge = !fw_edge && !fast_edge && !dc_edge;

   normal_stop_a: assert property (@(posedge clk) disable iff (srst)
      stop_state_q == MSTOP_ST_RUN && !run_cmd && no_edge |=> stop_state_q != MSTOP_ST_RUN && !motor_run_q)
      else $error("run withdrawn but motor still running");
   mode_select_a: assert property (@(posedge clk) disable iff (srst)
      stop_state_q == MSTOP_ST_RUN && stop_cmd && no_edge && stop_mode == MSTOP_MODE_RAMP
      |=> stop_state_q == MSTOP_ST_RAMP)
      else $error("ramp mode did not give ramp stop");
   freewheel_edge_a: assert property (@(posedge clk) disable iff (srst)
      asg[0] && $fell(cur[0]) |=> stop_state_q == MSTOP_ST_FREEWHEEL)
      else $error("freewheel edge ignored");
   restart_lock_a: assert property (@(posedge clk) disable iff (srst)
      $rose(restart_lock_q) |-> $past(input_stop_q) && !$past(auto_ok))
      else $error("restart lock set without cause");
   dc_restart_a: assert property (@(posedge clk) disable iff (srst)
      stop_state_q == MSTOP_ST_DCINJ && input_stop_q && !dc_hold && run_cmd && !auto_ok && no_edge
      |=> restart_lock_q ##1 stop_state_q != MSTOP_ST_RUN)
      else $error("DC release restarted without new run");
   auto_freewheel_a: assert property (@(posedge clk) disable iff (srst)
      stop_state_q == MSTOP_ST_RAMP && auto_dc_inj_en && below_thd && !speed_zero && no_edge
      |=> stop_state_q == MSTOP_ST_FREEWHEEL)
      else $error("no switch to freewheel below threshold");
   thd_range_a: assert property (@(posedge clk) disable iff (srst)
      freewheel_thd_q >= `MSTOP_THD_MIN && freewheel_thd_q <= `MSTOP_THD_MAX)
      else $error("threshold out of range");
   fast_edge_a: assert property (@(posedge clk) disable iff (srst)
      fast_edge && !fw_edge |=> stop_state_q == MSTOP_ST_FAST)
      else $error("fast stop edge ignored");
   ramp_divide_a: assert property (@(posedge clk) disable iff (srst)
      ramp_divider == 4'h2 && !decel_sel_second && decel_time1 == 16'h0064 |=> fast_decel_time_q == 16'h0032)
      else $error("fast ramp not divided");
   divider_zero_a: assert property (@(posedge clk) disable iff (srst)
      ramp_divider == 4'h0 |=> fast_decel_time_q == `MSTOP_RAMP_MIN)
      else $error("zero divider not minimum ramp");
   dc_edge_a: assert property (@(posedge clk) disable iff (srst)
      dc_edge && !fw_edge && !fast_edge |=> stop_state_q == MSTOP_ST_DCINJ && !dc_second_level_q)
      else $error("DC injection edge ignored");
   unassigned_quiet_a: assert property (@(posedge clk) disable iff (srst)
      !asg[0] && !asg[1] && !asg[2] |-> no_edge)
      else $error("unassigned source triggered");
   dc_level_a: assert property (@(posedge clk) disable iff (srst)
      dc_second_level_q |-> stop_state_q == MSTOP_ST_DCINJ && dc_cnt_q >= 32'(DC_T1_CYC))
      else $error("level two before time one");
   single_edge_a: assert property (@(posedge clk) disable iff (srst)
      fw_edge |=> !fw_edge)
      else $error("one edge acted twice");
endmodule
`default_nettype wire

/* File: testbench/mstop_motor.sv */
// Motor and power stage model that turns drive state into a measured speed
`timescale 1ns/1ps
`default_nettype none
module mstop_motor (
   input wire logic clk, // Control clock
   input wire logic srst, // Synchronous reset
   input wire logic motor_run_q, // Drive is powering the motor
   input wire logic [12:0] run_speed, // Speed held while driven, 0.1 Hz
   input wire logic [12:0] dec_step, // Speed lost each cycle when not driven
   output logic [12:0] motor_speed // Measured speed, 0.1 Hz
);
   logic [12:0] speed_d;
   logic [12:0] speed_q;
   // Lumped load with a fixed slowdown, so every stop lasts a known number of cycles
   always_comb begin
      if (motor_run_q) begin
         speed_d = run_speed;
      end else if (speed_q > dec_step) begin
         speed_d = speed_q - dec_step;
      end else begin
         speed_d = 13'h0000;
      end
   end
   // Speed register
   always_ff @(posedge clk) begin
      if (srst) begin
         speed_q <= 13'h0000;
      end else begin
         speed_q <= speed_d;
      end
   end
   assign motor_speed = speed_q;
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench of the motor stop-mode controller
`timescale 1ns/1ps
`default_nettype none
`include "mstop_params.svh"
module testbench;
   import mstop_pkg::*;
   logic clk = 1'b0, srst = 1'b1, run_cmd = 1'b0, stop_cmd = 1'b0, auto_dc_inj_en = 1'b0;
   logic two_wire_ctrl = 1'b0, two_wire_level = 1'b0, decel_sel_second = 1'b0;
   mstop_mode_type stop_mode = MSTOP_MODE_RAMP;
   logic [5:0] freewheel_assign = 6'h00, fast_assign = 6'h00, dcinj_assign = 6'h00;
   logic [5:0] base_inputs = 6'h3F, extension_inputs = 6'h3F;
   logic [15:0] virtual_input_zero = 16'h0000, serial_command_word = 16'h0000, fieldbus_command_word = 16'h0000;
   logic [12:0] freewheel_thd = 13'h0002, run_speed = 13'h0064, dec_step = 13'h000A;
   logic [3:0] ramp_divider = 4'h4;
   logic [15:0] decel_time1 = 16'h0032, decel_time2 = 16'h0032;
   wire [12:0] motor_speed;
   mstop_state_type stop_state_q;
   logic motor_run_q, dc_second_level_q, restart_lock_q;
   logic [15:0] fast_decel_time_q;
   logic [12:0] freewheel_thd_q;
   int fail_count = 0, num_checks = 0;
   mstop_state_type exp_q[$];
   mstop_state_type last_st = MSTOP_ST_IDLE;
   // ----------------------------------------------------------------------------
   // Design, motor model and clock
   // ----------------------------------------------------------------------------
   mstop_ctrl #(.DC_T1_CYC(20), .DC_T2_CYC(30)) uut (.clk, .srst, .run_cmd, .stop_cmd, .stop_mode,
      .freewheel_assign, .fast_assign, .dcinj_assign, .base_inputs, .extension_inputs, .virtual_input_zero,
      .serial_command_word, .fieldbus_command_word, .two_wire_ctrl, .two_wire_level, .auto_dc_inj_en,
      .motor_speed, .freewheel_thd, .ramp_divider, .decel_sel_second, .decel_time1, .decel_time2,
      .stop_state_q, .motor_run_q, .dc_second_level_q, .restart_lock_q, .fast_decel_time_q, .freewheel_thd_q);
   mstop_motor motor (.clk, .srst, .motor_run_q, .run_speed, .dec_step, .motor_speed);
   always #10 clk = ~clk;
   // ----------------------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------------------
   task automatic stop_test();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: %s is %h, expected %h", $time, what, got, exp);
      end
   endtask
   task automatic check_state(input mstop_state_type got, input mstop_state_type exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t: state %0d, expected %0d", $time, got, exp);
      end
   endtask
   // Any state change that nobody announced is a mismatch, so stray triggers are caught
   always @(negedge clk) begin
      if (!srst && stop_state_q !== last_st) begin
         if (exp_q.size() == 0) begin
            fail_count++;
            $display("ERROR %0t: unexpected state %0d", $time, stop_state_q);
         end else begin
            check_state(stop_state_q, exp_q.pop_front());
         end
         check_val(16'(motor_run_q), 16'(stop_state_q == MSTOP_ST_RUN), "run flag");
         last_st = stop_state_q;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Bounded wait until the monitor has consumed every announced state
   task automatic wait_empty();
      int n;
      n = 0;
      while (exp_q.size() != 0 && n < 500) begin
         @(posedge clk);
         n++;
      end
      if (exp_q.size() != 0) begin
         fail_count++;
         $display("ERROR %0t: expected state change missing", $time);
         exp_q.delete();
      end
      tick(2);
      #1;
   endtask
   task automatic set_src(input int c, input logic v);
      if (c <= 6) base_inputs[c - 1] <= v;
      else if (c <= 12) extension_inputs[c - 7] <= v;
      else if (c < 32) virtual_input_zero[c - 16] <= v;
      else if (c < 48) serial_command_word[c - 32] <= v;
      else fieldbus_command_word[c - 48] <= v;
   endtask
   task automatic run_up();
      @(posedge clk);
      exp_q.push_back(MSTOP_ST_RUN);
      run_cmd <= 1'b1;
      wait_empty();
   endtask
   // ----------------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------------
   initial begin
      int c, k, e;
      logic lvl;
      mstop_state_type st;
      void'($urandom(60));
      tick(9);
      #1;
      check_val(fast_decel_time_q, 16'h0001, "reset ramp");
      check_val(16'(freewheel_thd_q), 16'(`MSTOP_THD_MIN), "reset threshold");
      check_val(16'(stop_state_q), 16'(MSTOP_ST_IDLE), "reset state");
      @(posedge clk);
      srst <= 1'b0;
      // Divider and threshold sweep, edges of both ranges included
      for (int d = 0; d < 12; d++) begin
         @(posedge clk);
         ramp_divider <= 4'(d);
         // Divider 2 gets a known first ramp so the in-design divide check has a case to act on
         decel_sel_second <= (d == 2) ? 1'b0 : 1'($urandom_range(0, 1));
         decel_time1 <= (d == 2) ? 16'h0064 : 16'($urandom_range(1, 65535));
         decel_time2 <= 16'($urandom_range(1, 65535));
         freewheel_thd <= (d < 4) ? 13'(d * 2500) : 13'($urandom_range(0, 8191));
         tick(2);
         #1;
         e = decel_sel_second ? decel_time2 : decel_time1;
         e = (ramp_divider == 0) ? 1 : e / ((ramp_divider > `MSTOP_DIV_MAX) ? 10 : ramp_divider);
         check_val(fast_decel_time_q, 16'((e == 0) ? 1 : e), "fast ramp");
         e = (freewheel_thd < `MSTOP_THD_MIN) ? 2 : ((freewheel_thd > `MSTOP_THD_MAX) ? 5000 : freewheel_thd);
         check_val(16'(freewheel_thd_q), 16'(e), "threshold");
      end
      freewheel_thd <= 13'h0032;
      // Every normal stop mode, ramp and freewheel by run withdrawal, fast and DC injection by stop command
      for (int m = 0; m < 4; m++) begin
         stop_mode <= mstop_mode_type'(m);
         run_up();
         exp_q.push_back(mstop_state_type'(m + 2));
         exp_q.push_back(MSTOP_ST_IDLE);
         @(posedge clk);
         if (m[0]) stop_cmd <= 1'b1;
         else run_cmd <= 1'b0;
         if (m == 3) begin
            tick(10);
            #1;
            check_val(16'(dc_second_level_q), 16'h0000, "level two early");
            tick(16);
            #1;
            check_val(16'(dc_second_level_q), 16'h0001, "level two");
         end
         wait_empty();
         @(posedge clk);
         run_cmd <= 1'b0;
         stop_cmd <= 1'b0;
      end
      // Low-speed switch to freewheel with automatic injection on
      auto_dc_inj_en <= 1'b1;
      dec_step <= 13'h0007;
      for (int m = 0; m < 2; m++) begin
         stop_mode <= mstop_mode_type'(m);
         run_up();
         exp_q.push_back(mstop_state_type'(m + 2));
         exp_q.push_back(MSTOP_ST_FREEWHEEL);
         exp_q.push_back(MSTOP_ST_IDLE);
         @(posedge clk);
         run_cmd <= 1'b0;
         wait_empty();
      end
      auto_dc_inj_en <= 1'b0;
      dec_step <= 13'h000A;
      stop_mode <= MSTOP_MODE_RAMP;
      // Unassigned sources toggle without any effect
      run_up();
      base_inputs <= 6'h00;
      extension_inputs <= 6'h00;
      fieldbus_command_word <= 16'hFFFF;
      tick(8);
      base_inputs <= 6'h3F;
      extension_inputs <= 6'h3F;
      fieldbus_command_word <= 16'h0000;
      tick(8);
      exp_q.push_back(MSTOP_ST_RAMP);
      exp_q.push_back(MSTOP_ST_IDLE);
      run_cmd <= 1'b0;
      wait_empty();
      // Source-driven stops on every channel kind, with and without auto restart
      for (int i = 0; i < 6; i++) begin
         k = i / 2;
         case (i)
            0, 5: c = 1 + $urandom_range(0, 5);
            1: c = 48 + $urandom_range(0, 15);
            2: c = 7 + $urandom_range(0, 5);
            3: c = 32 + $urandom_range(0, 15);
            default: c = 16 + $urandom_range(0, 15);
         endcase
         lvl = (k == 0) || (k == 1 && c <= 12);
         st = (k == 0) ? MSTOP_ST_FREEWHEEL : ((k == 1) ? MSTOP_ST_FAST : MSTOP_ST_DCINJ);
         @(posedge clk);
         two_wire_ctrl <= i[0] || i == 2;
         two_wire_level <= i[0] || i == 0;
         set_src(c, lvl);
         tick(2);
         freewheel_assign <= (k == 0) ? 6'(c) : 6'h00;
         fast_assign <= (k == 1) ? 6'(c) : 6'h00;
         dcinj_assign <= (k == 2) ? 6'(c) : 6'h00;
         tick(4);
         run_up();
         exp_q.push_back(st);
         @(posedge clk);
         set_src(c, !lvl);
         wait_empty();
         tick(22);
         #1;
         if (k == 2) check_val(16'(dc_second_level_q), 16'h0001, "input level two");
         exp_q.push_back(MSTOP_ST_IDLE);
         if (i[0]) exp_q.push_back(MSTOP_ST_RUN);
         @(posedge clk);
         set_src(c, lvl);
         wait_empty();
         if (i[0]) begin
            exp_q.push_back(MSTOP_ST_RAMP);
            exp_q.push_back(MSTOP_ST_IDLE);
         end else begin
            check_val(16'(restart_lock_q), 16'h0001, "lock set");
         end
         @(posedge clk);
         run_cmd <= 1'b0;
         wait_empty();
         check_val(16'(restart_lock_q), 16'h0000, "lock clear");
         freewheel_assign <= 6'h00;
         fast_assign <= 6'h00;
         dcinj_assign <= 6'h00;
         tick(2);
      end
      stop_test();
   end
   // Watchdog of 30000 cycles, well beyond the under one thousand cycles the sequence needs
   initial begin
      #(20 * 30000);
      fail_count++;
      $display("ERROR %0t: watchdog expired", $time);
      stop_test();
   end
endmodule
`default_nettype wire
